// ---- common/asrc_pkg.sv ----
// Package of constants and carrier types for the asynchronous static memory controller.
`default_nettype none
package asrc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int INDEX_W = 20;
  localparam int WORD_COUNT = 1048576;
  // Fastest grade figures, in nanoseconds.
  localparam int CYCLE_TIME_NS = 20;
  localparam int ADDRESS_ACCESS_TIME_NS = 20;
  localparam int SELECT_ACCESS_TIME_NS = 20;
  localparam int SELECT_TO_OUTPUT_FLOAT_NS = 9;
  localparam int ADDRESS_TO_WRITE_END_NS = 15;
  localparam int INPUT_SETUP_TO_WRITE_END_NS = 10;
  localparam int SELECT_LOW_TO_WRITE_END_NS = 15;
  // Least and longest times both round up; none below one cycle.
  localparam int CYCLE_TIME_CYC = (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_NS = (ADDRESS_ACCESS_TIME_NS > SELECT_ACCESS_TIME_NS) ?
    ADDRESS_ACCESS_TIME_NS : SELECT_ACCESS_TIME_NS;
  // Data is sampled once the access time has surely passed, hence round up.
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYC = (SELECT_TO_OUTPUT_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_LOW_NS = (ADDRESS_TO_WRITE_END_NS > SELECT_LOW_TO_WRITE_END_NS) ?
    ADDRESS_TO_WRITE_END_NS : SELECT_LOW_TO_WRITE_END_NS;
  localparam int WRITE_LOW_CYC = (WRITE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (INPUT_SETUP_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;
  localparam logic [INDEX_W-1:0] INDEX_RESET = 20'h00000;

  typedef struct packed {
    logic write;
    logic [INDEX_W-1:0] word_index;
    logic data;
  } asrc_req_t;

  typedef struct packed {
    logic [INDEX_W-1:0] word_index;
    logic select_n;
    logic strobe_n;
    logic data_in;
  } asrc_pins_t;
endpackage
`default_nettype wire

// ---- src/asrc_ctrl.sv ----
// Controller that runs read and write cycles on an asynchronous one-bit static memory.
// Functional notes
// - Read needs strobe high and select low; memory drives stored bit.
// - Index stable 15 ns before write end, held after strobe rises.
// - Input bit set 10 ns before write end, held after it.
// - Select and strobe both low at least 15 ns before write end.
// - Successive cycles spaced by at least the 20 ns cycle time.
`default_nettype none
module asrc_ctrl (
  input wire logic ref_clk_i, // System clock, 100 MHz.
  input wire logic reset_i, // Synchronous reset, active high.
  input wire logic req_valid_i, // Request offered.
  input wire asrc_pkg::asrc_req_t req_i, // Request: write flag, index, data.
  output logic req_ready_o, // Request taken when valid and ready.
  output logic rd_valid_o, // One-cycle pulse: read data valid.
  output logic rd_data_o, // Read data bit.
  output asrc_pkg::asrc_pins_t pins_o, // Memory pins: index, select, strobe, data.
  input wire logic mem_q_i // Memory data output pin.
);
  // Phases of one memory cycle: idle, selected read, selected write, deselected gap.
  typedef enum {ST_IDLE, ST_RD, ST_WR, ST_GAP} asrc_state_t;

  asrc_state_t state;
  asrc_state_t next_state;
  logic [asrc_pkg::CNT_W-1:0] cnt;
  logic [asrc_pkg::CNT_W-1:0] next_cnt;
  logic [asrc_pkg::CNT_W-1:0] since_index;
  logic [asrc_pkg::CNT_W-1:0] next_since_index;
  logic is_write;
  logic take;
  logic spacing_ok;
  logic rd_last;
  logic wr_last;
  logic gap_last;
  logic cycle_end;
  logic [asrc_pkg::INDEX_W-1:0] word_index;
  logic select_n;
  logic strobe_n;
  logic data_in;

  // Index spacing is tracked apart from the phases, so shortening the gap can never
  // bring the next index transition inside the cycle time.
  assign spacing_ok = (since_index >= asrc_pkg::CNT_W'(asrc_pkg::CYCLE_TIME_CYC));
  assign req_ready_o = (state == ST_IDLE) && spacing_ok;
  assign take = req_valid_i && req_ready_o;

  // Last cycle of the read, write and gap phases.
  assign rd_last = (state == ST_RD) &&
    (cnt == asrc_pkg::CNT_W'(asrc_pkg::ACCESS_CYC - 1));
  // A write lasts for the longer of the pulse width and the input setup time.
  assign wr_last = (state == ST_WR) &&
    (cnt >= asrc_pkg::CNT_W'(asrc_pkg::WRITE_LOW_CYC - 1)) &&
    (cnt >= asrc_pkg::CNT_W'(asrc_pkg::SETUP_CYC - 1));
  assign gap_last = (state == ST_GAP) &&
    (cnt == asrc_pkg::CNT_W'(asrc_pkg::FLOAT_CYC - 1));
  // Select and strobe end together, whichever kind of cycle runs.
  assign cycle_end = is_write ? wr_last : rd_last;

  // Next phase of the sequencer.
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_state = req_i.write ? ST_WR : ST_RD;
        end
      end
      ST_RD: begin
        if (rd_last) begin
          next_state = ST_GAP;
        end
      end
      ST_WR: begin
        if (wr_last) begin
          next_state = ST_GAP;
        end
      end
      ST_GAP: begin
        // The deselected gap lets the output float before the index may move.
        if (gap_last) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // The phase counter restarts at zero on every phase change and rests in idle.
  always_comb begin
    next_cnt = cnt + 1'b1;
    if (next_state != state || state == ST_IDLE) begin
      next_cnt = '0;
    end
  end

  // Phase register.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Phase counter register.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // Kind of the running cycle, so the end of select need not decode the phase twice.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      is_write <= 1'b0;
    end else if (take) begin
      is_write <= req_i.write;
    end
  end

  // Cycles since the index last moved; it starts saturated so the first request
  // after reset is not held back, and it stops at its top instead of wrapping.
  always_comb begin
    next_since_index = since_index;
    if (take) begin
      next_since_index = '0;
    end else if (since_index != '1) begin
      next_since_index = since_index + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      since_index <= '1;
    end else begin
      since_index <= next_since_index;
    end
  end

  // The index is loaded on acceptance and held through the gap and the idle cycle after it,
  // which turns the zero hold after the strobe rises into two whole cycles of margin.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      word_index <= asrc_pkg::INDEX_RESET;
    end else if (take) begin
      word_index <= req_i.word_index;
    end
  end

  // The input bit follows the index, so its setup to the end of a write is the whole pulse.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      data_in <= 1'b0;
    end else if (take) begin
      data_in <= req_i.data;
    end
  end

  // Select is high from reset on, so the memory is idle with its output floating.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      select_n <= 1'b1;
    end else if (take) begin
      select_n <= 1'b0;
    end else if (cycle_end) begin
      select_n <= 1'b1;
    end
  end

  // The strobe falls and rises together with select on a write. The output then
  // never turns on during the write, at its start or at its end.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      strobe_n <= 1'b1;
    end else if (take) begin
      strobe_n <= ~req_i.write;
    end else if (cycle_end) begin
      strobe_n <= 1'b1;
    end
  end

  // All pin fields come straight from their flip-flops.
  always_comb begin
    pins_o.word_index = word_index;
    pins_o.select_n = select_n;
    pins_o.strobe_n = strobe_n;
    pins_o.data_in = data_in;
  end

  // Read data is taken on the last selected cycle, while the memory still drives.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_last;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rd_data_o <= 1'b0;
    end else if (rd_last) begin
      rd_data_o <= mem_q_i;
    end
  end
endmodule
`default_nettype wire

// ---- test/asrc_assertions.sv ----
// Port checks of the static memory controller.
`default_nettype none
module asrc_assertions (
  input wire logic ref_clk_i, // Clock.
  input wire logic reset_i, // Reset.
  input wire logic req_valid_i, // Offer.
  input wire asrc_pkg::asrc_req_t req_i, // Request.
  input wire logic req_ready_o, // Ready.
  input wire logic rd_valid_o, // Read done.
  input wire logic rd_data_o, // Read bit.
  input wire asrc_pkg::asrc_pins_t pins_o, // Pins.
  input wire logic mem_q_i // Data out.
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  logic take;
  assign take = req_valid_i && req_ready_o;
  sequence rd_win; (!pins_o.select_n && pins_o.strobe_n)[*2]; endsequence
  sequence wr_win; (!pins_o.select_n && !pins_o.strobe_n)[*2]; endsequence
  AST_READ_CYCLE: assert property (take && !req_i.write |=> rd_win ##[1:2] $rose(pins_o.select_n))
    else $error("read window wrong");
  AST_WRITE_CYCLE: assert property (take && req_i.write |=> wr_win ##[1:2] $rose(pins_o.strobe_n))
    else $error("write window wrong");
  AST_INDEX_HOLD: assert property (take |=> pins_o.word_index == $past(req_i.word_index) ##1 $stable(pins_o.word_index)[*2])
    else $error("index not held");
  AST_DATA_HOLD: assert property (take && req_i.write |=> pins_o.data_in == $past(req_i.data) ##1 $stable(pins_o.data_in)[*2])
    else $error("data not held");
  AST_READ_RESULT: assert property (take && !req_i.write |=> ##[2:3] (rd_valid_o && rd_data_o == $past(mem_q_i)))
    else $error("read result wrong");
  AST_READY_GAP: assert property (take |=> (!req_ready_o)[*3] ##[1:2] req_ready_o)
    else $error("spacing wrong");
  AST_VALID_PULSE: assert property (rd_valid_o |=> !rd_valid_o)
    else $error("valid too long");
  AST_STROBE_SEL: assert property (!pins_o.strobe_n |-> !pins_o.select_n)
    else $error("strobe without select");
endmodule
`default_nettype wire

// ---- test/asrc_ctrl_bench.sv ----
// Self-checking bench of the static memory controller.
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((e) !== (a)) begin err_count++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module asrc_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i, reset_i, req_valid_i, req_ready_o, rd_valid_o, rd_data_o, mem_q_i;
  asrc_pkg::asrc_req_t req_i;
  asrc_pkg::asrc_pins_t pins_o;
  int err_count, checks;
  asrc_ctrl asrc_ctrl_i (.ref_clk_i, .reset_i, .req_valid_i, .req_i, .req_ready_o,
    .rd_valid_o, .rd_data_o, .pins_o, .mem_q_i);
  asrc_mem_model asrc_mem_model_i (.pins_i(pins_o), .q_o(mem_q_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic req(input logic w, input logic [19:0] a, input logic d);
    int n;
    n = 0;
    req_i = {w, a, d};
    req_valid_i = 1'b1;
    while (req_ready_o !== 1'b1 && n < 20) begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n >= 20) begin
      err_count++;
    end
    @(negedge ref_clk_i);
    req_valid_i = 1'b0;
    // One idle edge keeps the next call from raising valid in this time step.
    @(negedge ref_clk_i);
  endtask
  task automatic rd(input logic [19:0] a, input logic e);
    int n;
    n = 0;
    req(1'b0, a, 1'b0);
    while (rd_valid_o !== 1'b1 && n < 8) begin
      @(negedge ref_clk_i);
      n++;
    end
    `CHK("rd_valid", 1'b1, rd_valid_o)
    `CHK("rd_data", e, rd_data_o)
  endtask
  task automatic t_reset;
    `CHK("select_n", 1'b1, pins_o.select_n)
    `CHK("ready", 1'b1, req_ready_o)
    `CHK("strobe_n", 1'b1, pins_o.strobe_n)
    `CHK("rd_valid", 1'b0, rd_valid_o)
  endtask
  // Both ends of the index range, written back to back, then read back.
  task automatic t_pattern;
    req(1'b1, 20'h00000, 1'b1);
    req(1'b1, 20'hFFFFF, 1'b1);
    req(1'b1, 20'h55555, 1'b0);
    rd(20'h00000, 1'b1);
    rd(20'hFFFFF, 1'b1);
    rd(20'h55555, 1'b0);
  endtask
  task automatic t_overwrite;
    req(1'b1, 20'hFFFFF, 1'b0);
    rd(20'hFFFFF, 1'b0);
    rd(20'h00000, 1'b1);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    reset_i = 1'b1;
    req_valid_i = 1'b0;
    req_i = '0;
    repeat (10) @(negedge ref_clk_i);
    reset_i = 1'b0;
    @(negedge ref_clk_i);
    t_reset;
    t_pattern;
    t_overwrite;
    results;
  end
  initial begin
    #20000;
    err_count++;
    results;
  end
endmodule
bind asrc_ctrl asrc_assertions asrc_assertions_i (.ref_clk_i, .reset_i, .req_valid_i,
  .req_i, .req_ready_o, .rd_valid_o, .rd_data_o, .pins_o, .mem_q_i);
`default_nettype wire

// ---- test/asrc_mem_model.sv ----
// Behavioural one-bit static memory facing the controller.
`default_nettype none
module asrc_mem_model (
  input wire asrc_pkg::asrc_pins_t pins_i, // Pins.
  output logic q_o // Data out.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mem [asrc_pkg::WORD_COUNT];
  logic [asrc_pkg::INDEX_W-1:0] wr_index;
  logic wr_bit;
  logic writing = 1'b0;
  logic drive;
  logic bit_d;
  logic float_d;
  // The word is stored at the end of the overlap of select and strobe, so only the
  // index and bit that stand when the write ends count.
  always @(pins_i) begin
    if (!pins_i.select_n && !pins_i.strobe_n) begin
      wr_index = pins_i.word_index;
      wr_bit = pins_i.data_in;
      writing = 1'b1;
    end else if (writing) begin
      mem[wr_index] = wr_bit;
      writing = 1'b0;
    end
  end
  assign drive = !pins_i.select_n && pins_i.strobe_n;
  // The old bit lingers after an index change; the new one lands within the access time.
  assign #15 bit_d = mem[pins_i.word_index];
  // Turn-off and turn-on take 9 ns, inside the float maximum and past the drive minimum.
  assign #9 float_d = !drive;
  // A released pin shows the inverted bit, so a late sample cannot pass by luck.
  assign q_o = float_d ? ~bit_d : bit_d;
endmodule
`default_nettype wire
